// File: rtl/hist_pkg.sv
// Constants and carriers for the host interrupt status block, bits 19 down to 5
package hist_pkg;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int unsigned HIST_BIT_TIMER_WRAP = 19;
  localparam int unsigned HIST_BIT_RSVD_18 = 18;
  localparam int unsigned HIST_BIT_POWER_EVENT = 17;
  localparam int unsigned HIST_BIT_TXS_OVERFLOW = 16;
  localparam int unsigned HIST_BIT_RX_WATCHDOG = 15;
  localparam int unsigned HIST_BIT_RX_ERROR = 14;
  localparam int unsigned HIST_BIT_TX_ERROR = 13;
  localparam int unsigned HIST_BIT_IO_SUMMARY = 12;
  localparam int unsigned HIST_BIT_RSVD_11 = 11;
  localparam int unsigned HIST_BIT_TXD_OVERRUN = 10;
  localparam int unsigned HIST_BIT_TXD_SPACE = 9;
  localparam int unsigned HIST_BIT_TXS_FULL = 8;
  localparam int unsigned HIST_BIT_TXS_LEVEL = 7;
  localparam int unsigned HIST_BIT_RX_DROPPED = 6;
  localparam int unsigned HIST_BIT_RSVD_5 = 5;
  localparam int unsigned HIST_BIT_LO = 5;
  localparam int unsigned HIST_BIT_HI = 19;

  // ****************************************************************
  // Widths, limits and reset values
  // ****************************************************************
  localparam int unsigned HIST_REG_W = 32;
  localparam int unsigned HIST_LEVEL_W = 8;
  localparam int unsigned HIST_TIMER_W = 16;
  localparam int unsigned HIST_LEN_W = 12;
  localparam logic [HIST_TIMER_W-1:0] HIST_TIMER_MAX = 16'hffff;
  localparam logic [HIST_LEN_W-1:0] HIST_RX_LEN_LIMIT = 12'h800;
  localparam logic [HIST_LEN_W-1:0] HIST_TAG_LEN_LIMIT = 12'h7fc;
  localparam logic [HIST_LEVEL_W-1:0] HIST_TXD_LEVEL_RST = 8'h48;
  localparam logic [HIST_LEVEL_W-1:0] HIST_TXS_LEVEL_RST = 8'h00;
  localparam logic [HIST_REG_W-1:0] HIST_STATUS_RST = 32'h0000_0000;
  localparam logic [HIST_REG_W-1:0] HIST_WRITABLE_MASK = 32'h000b_e7c0;
  localparam int unsigned HIST_SYNC_STAGES = 3;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic timer_tick;
    logic [HIST_TIMER_W-1:0] timer_count_value;
    logic power_mgmt_pending;
    logic txs_overflow;
    logic rx_frame_end;
    logic [HIST_LEN_W-1:0] rx_frame_len;
    logic rx_tag_inserted;
    logic [HIST_LEN_W-1:0] rx_orig_len;
    logic rx_error;
    logic tx_error;
    logic txd_write_try;
    logic txd_full;
    logic [HIST_LEVEL_W-1:0] txd_free_blocks;
    logic txs_full;
    logic [HIST_LEVEL_W-1:0] txs_used_words;
    logic rx_frame_dropped;
  } hist_events_t;

  typedef struct packed {
    logic wr_en;
    logic [HIST_REG_W-1:0] wr_data;
    logic [HIST_LEVEL_W-1:0] txd_level;
    logic [HIST_LEVEL_W-1:0] txs_level;
  } hist_host_t;

endpackage

// File: rtl/hist_pin_sync.sv
// Three-stage synchroniser with agreement filter for one external level
`timescale 1ns/1ps
`default_nettype none
module hist_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } hist_sync_state_t;

  hist_sync_state_t st_r;
  hist_sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
        st_nxt.level = st_r.s3;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;
endmodule
`default_nettype wire

// File: rtl/hist_status.sv
// Host interrupt status register, event bits 19 down to 5
// How it works
// - Timer wrap from zero to all ones sets bit 19.
// - Power-management event from control-register selections sets bit 17.
// - Bit 17 sets even when the wake indicator output is disabled.
// - Writing one clears bit 17 only while power_mgmt_pending is low; a pending event keeps it set.
// - Power event reaches the interrupt output without the deassertion interval.
// - Transmit status FIFO overflow sets bit 16.
// - Received packet longer than 2048 bytes sets bit 15.
// - Tag insertion on untagged frame over 2044 bytes also sets bit 15.
// - Receiver error sets bit 14.
// - Transmitter error sets bit 13.
// - Bit 12 is a read-only summary of pending I/O interrupts.
// - Write to full transmit data FIFO sets bit 10.
// - Transmit data free space above programmed level sets bit 9.
// - Transmit status FIFO becoming full sets bit 8.
// - Transmit status fill exceeding programmed level sets bit 7.
// - Each dropped receive frame sets bit 6.
// - Write one clears a flag; write zero leaves it.
// - Flags record events regardless of interrupt enables.
// - Data-available level is 8 bits, 64-byte blocks, reset 48h.
// - Status level fires when used words exceed the programmed level.
`timescale 1ns/1ps
`default_nettype none
module hist_status (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire hist_pkg::hist_events_t events,
  input wire hist_pkg::hist_host_t host,
  input wire logic io_irq_pin,
  output logic [hist_pkg::HIST_REG_W-1:0] interrupt_event_status,
  output logic power_event_direct,
  output logic [hist_pkg::HIST_LEVEL_W-1:0] txd_level_r_out,
  output logic [hist_pkg::HIST_LEVEL_W-1:0] txs_level_r_out
);
  import hist_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [HIST_REG_W-1:0] status;
    logic [HIST_TIMER_W-1:0] prev_count;
    logic prev_txs_full;
    logic prev_txs_above;
    logic prev_txd_above;
    logic [HIST_LEVEL_W-1:0] txd_level;
    logic [HIST_LEVEL_W-1:0] txs_level;
  } hist_state_t;

  hist_state_t st_r;
  hist_state_t st_nxt;
  logic io_summary;
  logic [HIST_REG_W-1:0] set_vec;
  logic [HIST_REG_W-1:0] clr_vec;
  logic timer_wrap;
  logic rx_long;
  logic tag_long;
  logic txs_above;
  logic txd_above;

  // ****************************************************************
  // External I/O interrupt summary, from another domain
  // ****************************************************************
  hist_pin_sync u_io_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_in(io_irq_pin),
    .level_out(io_summary)
  );

  // ****************************************************************
  // Event detection
  // ****************************************************************
  always_comb begin
    timer_wrap = events.timer_tick && (st_r.prev_count == '0)
                 && (events.timer_count_value == HIST_TIMER_MAX);
    rx_long = events.rx_frame_end && (events.rx_frame_len > HIST_RX_LEN_LIMIT);
    tag_long = events.rx_frame_end && events.rx_tag_inserted
               && (events.rx_orig_len > HIST_TAG_LEN_LIMIT);
    txs_above = events.txs_used_words > st_r.txs_level;
    txd_above = events.txd_free_blocks > st_r.txd_level;
    set_vec = '0;
    set_vec[HIST_BIT_TIMER_WRAP] = timer_wrap;
    // Taken straight from the power control logic, not from the wake pin
    set_vec[HIST_BIT_POWER_EVENT] = events.power_mgmt_pending;
    set_vec[HIST_BIT_TXS_OVERFLOW] = events.txs_overflow;
    set_vec[HIST_BIT_RX_WATCHDOG] = rx_long || tag_long;
    set_vec[HIST_BIT_RX_ERROR] = events.rx_error;
    set_vec[HIST_BIT_TX_ERROR] = events.tx_error;
    set_vec[HIST_BIT_TXD_OVERRUN] = events.txd_write_try && events.txd_full;
    set_vec[HIST_BIT_TXD_SPACE] = txd_above && !st_r.prev_txd_above;
    set_vec[HIST_BIT_TXS_FULL] = events.txs_full && !st_r.prev_txs_full;
    set_vec[HIST_BIT_TXS_LEVEL] = txs_above && !st_r.prev_txs_above;
    set_vec[HIST_BIT_RX_DROPPED] = events.rx_frame_dropped;
    clr_vec = '0;
    if (host.wr_en) begin
      clr_vec = host.wr_data & HIST_WRITABLE_MASK;
    end
  end

  // ****************************************************************
  // Register update
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      // Set beats clear in the same cycle; enables play no part here
      st_nxt.status = ((st_r.status & ~clr_vec) | set_vec) & HIST_WRITABLE_MASK;
      st_nxt.prev_count = events.timer_count_value;
      st_nxt.prev_txs_full = events.txs_full;
      st_nxt.prev_txs_above = txs_above;
      st_nxt.prev_txd_above = txd_above;
      st_nxt.txd_level = host.txd_level;
      st_nxt.txs_level = host.txs_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.status <= HIST_STATUS_RST;
      st_r.prev_count <= '0;
      st_r.prev_txs_full <= 1'b0;
      st_r.prev_txs_above <= 1'b0;
      st_r.prev_txd_above <= 1'b0;
      st_r.txd_level <= HIST_TXD_LEVEL_RST;
      st_r.txs_level <= HIST_TXS_LEVEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    interrupt_event_status = st_r.status;
    interrupt_event_status[HIST_BIT_IO_SUMMARY] = io_summary;
    interrupt_event_status[HIST_BIT_RSVD_18] = 1'b0;
    interrupt_event_status[HIST_BIT_RSVD_11] = 1'b0;
    interrupt_event_status[HIST_BIT_RSVD_5] = 1'b0;
  end

  // Marks the power flag as exempt from the deassertion interval downstream
  assign power_event_direct = st_r.status[HIST_BIT_POWER_EVENT];
  assign txd_level_r_out = st_r.txd_level;
  assign txs_level_r_out = st_r.txs_level;
endmodule
`default_nettype wire

// File: bench/hist_status_assertions.sv
// Concurrent checks on the host interrupt status ports
`timescale 1ns/1ps
`default_nettype none
module hist_status_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire hist_pkg::hist_events_t events,
  input wire hist_pkg::hist_host_t host,
  input wire logic io_irq_pin,
  input wire logic [hist_pkg::HIST_REG_W-1:0] interrupt_event_status,
  input wire logic power_event_direct,
  input wire logic [hist_pkg::HIST_LEVEL_W-1:0] txd_level_r_out,
  input wire logic [hist_pkg::HIST_LEVEL_W-1:0] txs_level_r_out
);
  import hist_pkg::*;
  logic [31:0] s;
  assign s = interrupt_event_status;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****
  // Event capture and clearing
  // ****
  a_ovf_set: assert property (clk_en && events.txs_overflow |=> s[16])
    else $error("overflow flag not set");
  a_overrun_set: assert property (
    clk_en && events.txd_write_try && events.txd_full |=> s[10]) else $error("overrun not set");
  a_drop_set: assert property (clk_en && events.rx_frame_dropped |=> s[6])
    else $error("drop flag not set");
  a_wdog_set: assert property (
    clk_en && events.rx_frame_end && events.rx_frame_len > 12'h800 |=> s[15])
    else $error("watchdog flag not set");
  a_pwr_set: assert property (clk_en && events.power_mgmt_pending |=> s[17])
    else $error("power flag not set");
  a_pwr_direct: assert property (
    (clk_en && events.power_mgmt_pending) [*2] |=> power_event_direct)
    else $error("direct power output late");
  a_rsvd_zero: assert property ((s & 32'hfff4_083f) == 32'h0)
    else $error("reserved bit set");
  a_freeze_hold: assert property (!clk_en |=> $stable(s))
    else $error("status moved while clock enable low");
  a_one_clear: assert property (
    clk_en && host.wr_en && host.wr_data[13] && !events.tx_error |=> !s[13])
    else $error("write one did not clear");
  c_pwr_hold: cover property (s[17] && host.wr_en && events.power_mgmt_pending);
  c_wrap: cover property (s[19]);
  c_summary: cover property (s[12]);
endmodule
bind hist_status hist_status_chk chk_u (.sys_clk, .rst_b, .clk_en, .events, .host,
  .io_irq_pin, .interrupt_event_status, .power_event_direct, .txd_level_r_out,
  .txs_level_r_out);
`default_nettype wire

// File: bench/hist_status_bench.sv
// Self-checking bench for the host interrupt status block
`timescale 1ns/1ps
`default_nettype none
module hist_status_bench;
  import hist_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic io_pin = 1'b0;
  hist_events_t ev = '0;
  hist_host_t hw = '{1'b0, 32'h0, 8'h48, 8'h00};
  logic [31:0] st;
  logic pwr;
  logic [7:0] tdl;
  logic [7:0] tsl;
  logic ce = 1'b1;
  int err_total = 0;
  int compares = 0;
  always #20 sys_clk = ~sys_clk;
  hist_status dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce), .events(ev),
    .host(hw), .io_irq_pin(io_pin), .interrupt_event_status(st),
    .power_event_direct(pwr), .txd_level_r_out(tdl), .txs_level_r_out(tsl));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic bit_is(input int b, input logic v);
    chk({31'h0, st[b]}, {31'h0, v});
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge sys_clk);
    hw.wr_en = 1'b1;
    hw.wr_data = d;
    @(negedge sys_clk);
    hw.wr_en = 1'b0;
  endtask
  task automatic print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_pulses;
    int b[5] = '{16, 14, 13, 10, 6};
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk);
      ev.txs_overflow = (i == 0);
      ev.rx_error = (i == 1);
      ev.tx_error = (i == 2);
      ev.txd_write_try = (i == 3);
      ev.txd_full = (i == 3);
      ev.rx_frame_dropped = (i == 4);
      @(negedge sys_clk);
      ev = '0;
      bit_is(b[i], 1'b1);
      wr(32'h0);
      bit_is(b[i], 1'b1);
      wr(32'h1 << b[i]);
      bit_is(b[i], 1'b0);
    end
    $display("pulse events done");
  endtask
  task automatic frame(input logic [11:0] len, input logic tag, input logic [11:0] org,
                       input logic v);
    @(negedge sys_clk);
    ev.rx_frame_end = 1'b1;
    ev.rx_frame_len = len;
    ev.rx_tag_inserted = tag;
    ev.rx_orig_len = org;
    @(negedge sys_clk);
    ev = '0;
    bit_is(15, v);
    wr(32'h0000_8000);
  endtask
  task automatic t_frames;
    frame(12'h800, 1'b0, 12'h000, 1'b0);
    frame(12'h801, 1'b0, 12'h000, 1'b1);
    frame(12'h040, 1'b1, 12'h7fc, 1'b0);
    frame(12'h040, 1'b1, 12'h7fd, 1'b1);
    $display("frame length done");
  endtask
  task automatic t_freeze;
    @(negedge sys_clk);
    ce = 1'b0;
    ev.rx_error = 1'b1;
    @(negedge sys_clk);
    bit_is(14, 1'b0);
    ce = 1'b1;
    @(negedge sys_clk);
    ev = '0;
    bit_is(14, 1'b1);
    ce = 1'b0;
    hw.wr_en = 1'b1;
    hw.wr_data = 32'h0000_4000;
    @(negedge sys_clk);
    hw.wr_en = 1'b0;
    bit_is(14, 1'b1);
    ce = 1'b1;
    wr(32'h0000_4000);
    bit_is(14, 1'b0);
    $display("clock enable freeze done");
  endtask
  task automatic t_timer;
    @(negedge sys_clk);
    ev.timer_tick = 1'b1;
    ev.timer_count_value = 16'h0001;
    @(negedge sys_clk);
    ev.timer_count_value = 16'h0000;
    @(negedge sys_clk);
    bit_is(19, 1'b0);
    ev.timer_count_value = 16'hffff;
    @(negedge sys_clk);
    ev = '0;
    bit_is(19, 1'b1);
    wr(32'h0008_0000);
    bit_is(19, 1'b0);
    $display("timer wrap done");
  endtask
  task automatic t_power;
    @(negedge sys_clk);
    ev.power_mgmt_pending = 1'b1;
    repeat (3) @(negedge sys_clk);
    bit_is(17, 1'b1);
    chk({31'h0, pwr}, 32'h1);
    wr(32'h0002_0000);
    bit_is(17, 1'b1);
    ev.power_mgmt_pending = 1'b0;
    wr(32'h0002_0000);
    bit_is(17, 1'b0);
    @(negedge sys_clk);
    chk({31'h0, pwr}, 32'h0);
    $display("power event done");
  endtask
  task automatic t_levels;
    hw.txd_level = 8'h04;
    hw.txs_level = 8'h03;
    // Levels must be registered before the fill values move
    @(negedge sys_clk);
    ev.txd_free_blocks = 8'h04;
    ev.txs_used_words = 8'h03;
    repeat (2) @(negedge sys_clk);
    chk(st, 32'h0);
    chk({24'h0, tdl}, 32'h04);
    chk({24'h0, tsl}, 32'h03);
    ev.txd_free_blocks = 8'h05;
    ev.txs_used_words = 8'h04;
    ev.txs_full = 1'b1;
    @(negedge sys_clk);
    chk(st, 32'h0000_0380);
    wr(32'h0000_0380);
    chk(st, 32'h0);
    ev = '0;
    $display("fifo levels done");
  endtask
  task automatic t_rsvd;
    io_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
    wr(32'hffff_ffff);
    chk(st, 32'h0000_1000);
    io_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(st, 32'h0);
    $display("reserved and summary done");
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    chk(st, 32'h0);
    chk({24'h0, tdl}, 32'h48);
    chk({24'h0, tsl}, 32'h00);
    rst_b = 1'b1;
    t_pulses();
    t_frames();
    t_timer();
    t_power();
    t_levels();
    t_freeze();
    t_rsvd();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
